// ### rtl/spictl_pkg.sv
// Constants shared by the serial clock and mode controller.
// Assumes a 32-bit AHB-Lite register bus with one byte register per word.

package spictl_pkg;

	// -------------------------------------------------------------------
	// Register indices and byte addresses
	// -------------------------------------------------------------------
	localparam logic [7:0]  IDX_BAUD   = 8'hF3;
	localparam logic [7:0]  IDX_CTRL   = 8'hF4;
	localparam logic [7:0]  IDX_DATA   = 8'hF5;
	localparam logic [7:0]  IDX_MODE   = 8'hF6;
	localparam logic [7:0]  IDX_FLAGS  = 8'hF7;
	localparam logic [7:0]  IDX_IMASK  = 8'hF8;
	localparam logic [31:0] ADDR_BAUD  = {22'h000000, IDX_BAUD, 2'b00};
	localparam logic [31:0] ADDR_CTRL  = {22'h000000, IDX_CTRL, 2'b00};
	localparam logic [31:0] ADDR_DATA  = {22'h000000, IDX_DATA, 2'b00};
	localparam logic [31:0] ADDR_MODE  = {22'h000000, IDX_MODE, 2'b00};
	localparam logic [31:0] ADDR_FLAGS = {22'h000000, IDX_FLAGS, 2'b00};
	localparam logic [31:0] ADDR_IMASK = {22'h000000, IDX_IMASK, 2'b00};

	// -------------------------------------------------------------------
	// Field positions and writable masks
	// -------------------------------------------------------------------
	localparam int          CTRL_SELEN_BIT  = 6;
	localparam int          CTRL_ORDER_BIT  = 5;
	localparam int          CTRL_ROLE_BIT   = 4;
	localparam int          CTRL_CLOCK_POLARITY_BIT   = 3;
	localparam int          CTRL_CLOCK_PHASE_BIT   = 2;
	localparam logic [7:0]  CTRL_WMASK      = 8'h7C;
	localparam logic [7:0]  MODE_WMASK      = 8'h97;
	localparam int          FLG_OVERRUN_BIT = 7;
	localparam int          FLG_DONE_BIT    = 6;
	localparam int          FLG_CORRUPT_BIT = 4;
	localparam int          FLG_SELDET_BIT  = 3;
	localparam int          FLG_SELLOST_BIT = 2;
	localparam int          FLG_RXFULL_BIT  = 1;
	localparam int          FLG_TXEMPTY_BIT = 0;
	localparam logic [7:0]  FLG_STICKY_MASK = 8'hBE;

	// -------------------------------------------------------------------
	// Reset values
	// -------------------------------------------------------------------
	localparam logic [7:0]  BAUD_RESET  = 8'h00;
	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	localparam logic [7:0]  DATA_RESET  = 8'h00;
	localparam logic [7:0]  MODE_RESET  = 8'h00;
	localparam logic [7:0]  FLAGS_RESET = 8'h41;
	localparam logic [7:0]  IMASK_RESET = 8'h00;
	localparam logic [7:0]  IDLE_FILL   = 8'hFF;

	// -------------------------------------------------------------------
	// AHB-Lite encodings
	// -------------------------------------------------------------------
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic        HRESP_OKAY    = 1'b0;

endpackage

// ### rtl/spictl_baud.sv
// Baud timer: an 8-bit reload down-counter producing serial clock events.
// Assumes run is held high only while a master frame is in progress.

`timescale 1ns/100ps

module spictl_baud
	import spictl_pkg::*;
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       run,
	input  wire logic [7:0] reload,
	output wire logic       tick
);

	logic [7:0] cnt_q;
	logic [7:0] cnt_d;

	// -------------------------------------------------------------------
	// Counter
	// -------------------------------------------------------------------
	// An event fires on the step that would pass from zero to the top.
	assign tick  = run && (cnt_q == 8'h00);
	// Idle timer sits at the reload value, so the first event of a frame
	// comes a full reload period after the start.
	assign cnt_d = !run ? reload : (tick ? reload : cnt_q - 8'h01);

	// Every value from zero to the top counts reload plus one cycles.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= BAUD_RESET;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule

// ### rtl/spictl_top.sv
// Serial clock and mode controller: AHB-Lite registers, baud timer,
// master and slave shifter and pin steering for a byte-wide serial port.
// Assumes pin inputs are already synchronous to hclk.
//
// Summary of operation
// - Master serial clock comes from an 8-bit down-counter, used only in master role.
// - Counter underflow reloads from baud_reload and emits one serial clock event.
// - Each event toggles the clock; rate is system clock over twice reload plus one.
// - Every reload value from 00 to FF is legal.
// - baud_reload is 8-bit write-only, reset zero.
// - bit_order 0 sends LSB first, 1 sends MSB first.
// - role_select 0 is slave driving MISO; 1 is master driving MOSI and clock.
// - clock_polarity 0 idles low, 1 idles high.
// - clock_phase 0: no edge before data; first edge latches, next shifts.
// - clock_phase 1: edge before data; next edge latches, following shifts.
// - Six byte registers at F3 to F8; flags reset to 41.
// - word_width_select 000 means eight bits, otherwise one to seven.
// - Data read returns receive buffer; data write loads transmit buffer.
// - Overrun flag sets when a word completes unread; cleared by flags read.
//
// The AHB-Lite register port was left to the implementer.

`timescale 1ns/100ps

module spictl_top
	import spictl_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output wire logic [31:0] hrdata,
	output wire logic        hreadyout,
	output wire logic        hresp,
	input  wire logic        sck_i,
	output wire logic        sck_o,
	output wire logic        sck_oe,
	input  wire logic        mosi_i,
	output wire logic        mosi_o,
	output wire logic        mosi_oe,
	input  wire logic        miso_i,
	output wire logic        miso_o,
	output wire logic        miso_oe,
	input  wire logic        sel_n_i,
	output wire logic        irq
);

	// -------------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------------
	// Bits per word from the width field.
	function automatic logic [3:0] word_bits(input logic [2:0] code);
		word_bits = (code == 3'h0) ? 4'h8 : {1'b0, code};
	endfunction

	// Bit that leaves the shifter next; words sit right aligned.
	function automatic logic pick(input logic [7:0] sh, input logic [3:0] n, input logic msb);
		pick = msb ? sh[3'(n - 4'h1)] : sh[0];
	endfunction

	// One shift step of an n-bit word, new bit entering at the far end.
	function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] n,
	                                        input logic msb, input logic b);
		logic [7:0] r;
		r = sh;
		if (msb) begin
			r = {sh[6:0], b};
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (i < int'(n) - 1) begin
					r[i] = sh[i + 1];
				end else if (i == int'(n) - 1) begin
					r[i] = b;
				end
			end
		end
		shift_in = r;
	endfunction

	// -------------------------------------------------------------------
	// State
	// -------------------------------------------------------------------
	logic        dp_valid_q;
	logic        dp_write_q;
	logic [31:0] dp_addr_q;
	logic [7:0]  baud_q;
	logic [7:0]  ctrl_q;
	logic [7:0]  mode_q;
	logic [7:0]  imask_q;
	logic [7:0]  sticky_q;
	logic [7:0]  sticky_d;
	logic [7:0]  txb_q;
	logic        tx_full_q;
	logic [7:0]  rxb_q;
	logic        rx_full_q;
	logic [7:0]  sh_q;
	logic [7:0]  sh_d;
	logic        samp_q;
	logic        busy_q;
	logic        busy_d;
	logic [3:0]  edge_q;
	logic        sck_q;
	logic        out_q;
	logic        sck_prev_q;
	logic        sel_prev_q;

	// -------------------------------------------------------------------
	// Bus decode
	// -------------------------------------------------------------------
	// Writes land in the data phase, when hwdata is valid.
	wire         addr_take  = hsel && hready && (htrans == HTRANS_NONSEQ);
	wire         wr_phase   = dp_valid_q && dp_write_q;
	wire         rd_phase   = dp_valid_q && !dp_write_q;
	wire         we_baud    = wr_phase && (dp_addr_q == ADDR_BAUD);
	wire         we_ctrl    = wr_phase && (dp_addr_q == ADDR_CTRL);
	wire         we_data    = wr_phase && (dp_addr_q == ADDR_DATA);
	wire         we_mode    = wr_phase && (dp_addr_q == ADDR_MODE);
	wire         we_imask   = wr_phase && (dp_addr_q == ADDR_IMASK);
	wire         re_data    = rd_phase && (dp_addr_q == ADDR_DATA);
	wire         re_flags   = rd_phase && (dp_addr_q == ADDR_FLAGS);

	// -------------------------------------------------------------------
	// Mode decode
	// -------------------------------------------------------------------
	wire         master     = ctrl_q[CTRL_ROLE_BIT];
	wire         msb_first  = ctrl_q[CTRL_ORDER_BIT];
	wire         clock_polarity       = ctrl_q[CTRL_CLOCK_POLARITY_BIT];
	wire         clock_phase       = ctrl_q[CTRL_CLOCK_PHASE_BIT];
	wire [3:0]   nbits      = word_bits(mode_q[2:0]);
	wire [4:0]   two_n      = {nbits, 1'b0};
	wire [3:0]   last_edge  = 4'(two_n - 5'h01);
	// With the select enable clear the slave counts as always selected.
	wire         selected   = !ctrl_q[CTRL_SELEN_BIT] || !sel_n_i;
	wire         tick;

	// -------------------------------------------------------------------
	// Frame sequencing
	// -------------------------------------------------------------------
	// A master starts on a queued byte; a slave arms as soon as it is
	// selected and shifts out all ones if software queued nothing.
	wire         start      = !busy_q && (master ? tx_full_q : selected);
	wire [7:0]   load_val   = tx_full_q ? txb_q : IDLE_FILL;
	wire         slv_edge   = busy_q && selected && (sck_i != sck_prev_q);
	wire         sck_edge   = busy_q && (master ? tick : slv_edge);
	wire         leading    = !edge_q[0];
	wire         samp_ev    = sck_edge && (leading ^ clock_phase);
	// With phase one the very first edge only presents the first bit.
	wire         shft_ev    = sck_edge && !(leading ^ clock_phase) && !(clock_phase && edge_q == 4'h0);
	wire         fin        = sck_edge && (edge_q == last_edge);
	wire         abort      = busy_q && !master && !selected;
	wire         din        = master ? miso_i : mosi_i;
	// On the closing edge of phase one the latch and the final shift coincide.
	wire         bit_in     = (fin && clock_phase) ? din : samp_q;
	wire [7:0]   sh_shift   = shift_in(sh_q, nbits, msb_first, bit_in);
	wire         tx_take    = start && tx_full_q;
	wire         sel_fall   = ctrl_q[CTRL_SELEN_BIT] && sel_prev_q && !sel_n_i;
	wire         sel_rise   = ctrl_q[CTRL_SELEN_BIT] && !sel_prev_q && sel_n_i;

	assign sh_d   = start ? load_val : ((fin || shft_ev) ? sh_shift : sh_q);
	assign busy_d = start ? 1'b1 : ((fin || abort) ? 1'b0 : busy_q);

	// -------------------------------------------------------------------
	// Flags and interrupt
	// -------------------------------------------------------------------
	// New events win over the read that clears them in the same cycle.
	wire [7:0]   events     = {fin && rx_full_q, 1'b0, 1'b0, abort, sel_fall,
	                           sel_rise && !busy_q, fin, 1'b0};
	wire [7:0]   flags_view = {sticky_q[7], !busy_q, sticky_q[5:1], !tx_full_q};
	assign sticky_d = ((sticky_q & ~({8{re_flags}} & FLG_STICKY_MASK)) | events) & FLG_STICKY_MASK;
	assign irq      = |(flags_view & imask_q & FLG_STICKY_MASK);

	// -------------------------------------------------------------------
	// Read mux and bus answer
	// -------------------------------------------------------------------
	// The baud register is write only and reads as zero, as do holes.
	wire [7:0]   rd_byte    = (dp_addr_q == ADDR_CTRL)  ? ctrl_q :
	                          (dp_addr_q == ADDR_DATA)  ? rxb_q :
	                          (dp_addr_q == ADDR_MODE)  ? mode_q :
	                          (dp_addr_q == ADDR_FLAGS) ? flags_view :
	                          (dp_addr_q == ADDR_IMASK) ? imask_q : 8'h00;
	assign hrdata    = rd_phase ? {24'h000000, rd_byte} : 32'h00000000;
	assign hreadyout = 1'b1;
	assign hresp     = HRESP_OKAY;

	// -------------------------------------------------------------------
	// Pins
	// -------------------------------------------------------------------
	// Master owns clock and MOSI; a slave drives MISO only while selected.
	assign sck_o   = sck_q;
	assign sck_oe  = master;
	assign mosi_o  = out_q;
	assign mosi_oe = master;
	assign miso_o  = out_q;
	assign miso_oe = !master && selected;

	// -------------------------------------------------------------------
	// Baud timer
	// -------------------------------------------------------------------
	spictl_baud u_baud (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     (busy_q && master),
		.reload  (baud_q),
		.tick    (tick)
	);

	// Bus address phase capture.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_q <= 1'b0;
			dp_write_q <= 1'b0;
			dp_addr_q  <= 32'h00000000;
		end else if (hready) begin
			dp_valid_q <= addr_take;
			dp_write_q <= hwrite;
			dp_addr_q  <= haddr;
		end
	end

	// Configuration registers; reserved bits never store.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			baud_q  <= BAUD_RESET;
			ctrl_q  <= CTRL_RESET;
			mode_q  <= MODE_RESET;
			imask_q <= IMASK_RESET;
		end else begin
			if (we_baud) baud_q <= hwdata[7:0];
			if (we_ctrl) ctrl_q <= hwdata[7:0] & CTRL_WMASK;
			if (we_mode) mode_q <= hwdata[7:0] & MODE_WMASK;
			if (we_imask) imask_q <= hwdata[7:0] & FLG_STICKY_MASK;
		end
	end

	// Transmit and receive buffers; a write in the take cycle is kept.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txb_q     <= DATA_RESET;
			tx_full_q <= 1'b0;
			rxb_q     <= DATA_RESET;
			rx_full_q <= 1'b0;
			sticky_q  <= 8'h00;
		end else begin
			if (we_data) txb_q <= hwdata[7:0];
			tx_full_q <= we_data || (tx_full_q && !tx_take);
			if (fin) rxb_q <= sh_shift;
			rx_full_q <= fin || (rx_full_q && !re_data);
			sticky_q  <= sticky_d;
		end
	end

	// Shifter, edge count and clock line.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sh_q       <= DATA_RESET;
			samp_q     <= 1'b0;
			busy_q     <= 1'b0;
			edge_q     <= 4'h0;
			sck_q      <= 1'b0;
			out_q      <= 1'b0;
			sck_prev_q <= 1'b0;
			sel_prev_q <= 1'b1;
		end else begin
			sh_q       <= sh_d;
			busy_q     <= busy_d;
			out_q      <= pick(sh_d, nbits, msb_first);
			sck_prev_q <= sck_i;
			sel_prev_q <= sel_n_i;
			if (samp_ev) samp_q <= din;
			edge_q     <= start ? 4'h0 : (sck_edge ? edge_q + 4'h1 : edge_q);
			// Idle level follows polarity; each timer event is one edge.
			sck_q      <= (!busy_d || start) ? clock_polarity : (tick && master ? ~sck_q : sck_q);
		end
	end

endmodule

// ### testbench/spictl_top_asserts.sv
// Port checker for the serial controller, bound to spictl_top.
// Assumes hready follows hreadyout and control is not rewritten mid-frame.
`timescale 1ns/100ps
module spictl_top_chk
	import spictl_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        sck_o,
	input wire logic        sck_oe,
	input wire logic        mosi_oe,
	input wire logic        miso_oe
);
	// ---------------------------------------------------------------
	// Bus shadow and clock edge spacing
	// ---------------------------------------------------------------
	logic        wr_q, rd_q, sck_q;
	logic [31:0] adr_q;
	logic [7:0]  ctl_q, baud_q, gap_q;
	wire         ap     = hsel && hready && htrans == HTRANS_NONSEQ;
	wire         ctl_wr = wr_q && adr_q == ADDR_CTRL;
	wire         edge_s = sck_o != sck_q;
	// Shadows of role and divider; the gap saturates so long idle spans never wrap.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wr_q, rd_q, sck_q, adr_q, ctl_q, baud_q, gap_q} <= '0;
		end else begin
			wr_q  <= ap && hwrite;
			rd_q  <= ap && !hwrite;
			adr_q <= haddr;
			sck_q <= sck_o;
			gap_q <= edge_s ? 8'h00 : gap_q + {7'h00, gap_q != 8'hFF};
			if (ctl_wr)
				ctl_q <= hwdata[7:0] & CTRL_WMASK;
			if (wr_q && adr_q == ADDR_BAUD)
				baud_q <= hwdata[7:0];
		end
	end

	chk_oe_master: assert property (@(posedge hclk) disable iff (!hresetn)
		ctl_q[CTRL_ROLE_BIT] |-> sck_oe && mosi_oe && !miso_oe) else $error("master pin enables wrong");
	chk_slave_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		!ctl_q[CTRL_ROLE_BIT] |-> !sck_oe && !mosi_oe) else $error("slave drives clock or mosi");
	chk_edge_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
		edge_s && sck_oe && !$past(ctl_wr, 2) |-> gap_q >= baud_q) else $error("clock edges too close");
	chk_clock_master_only: assert property (@(posedge hclk) disable iff (!hresetn)
		edge_s && !$past(ctl_wr, 2) |-> ctl_q[CTRL_ROLE_BIT]) else $error("clock moved outside master role");
	chk_idle_level: assert property (@(posedge hclk) disable iff (!hresetn)
		ctl_wr |-> ##2 sck_o == $past(hwdata[CTRL_CLOCK_POLARITY_BIT], 2)) else $error("idle clock level wrong");
	chk_baud_hidden: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_q && adr_q == ADDR_BAUD |-> hrdata == 32'h00000000) else $error("reload value readable");
	chk_ctrl_readback: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_q && adr_q == ADDR_CTRL |-> hrdata == {24'h000000, ctl_q}) else $error("control readback wrong");
	chk_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_q |-> hrdata[31:8] == 24'h000000) else $error("upper read bits set");
endmodule

bind spictl_top spictl_top_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
	.hrdata, .sck_o, .sck_oe, .mosi_oe, .miso_oe);

// ### testbench/spictl_far_end.sv
// Far-end model on the serial pins.
// Assumes MOSI and MISO share one line, so a master hears its own data.
`timescale 1ns/100ps
module spictl_far_end (
	input  wire logic hclk,
	input  wire logic mosi_o,
	input  wire logic mosi_oe,
	output wire logic miso_i,
	output logic      mosi_i  = 1'b0,
	output logic      sck_i   = 1'b0,
	output logic      sel_n_i = 1'b1
);
	// ---------------------------------------------------------------
	// Shared data line
	// ---------------------------------------------------------------
	// The shorted line is a plain wire, so the master hears its own bit with no
	// extra cycle of delay; when nobody drives it the pull-up holds it high.
	assign miso_i = mosi_oe ? mosi_o : 1'b1;

	// Slave data input toggles so that a stuck input would show.
	always @(posedge hclk) begin
		mosi_i <= ~mosi_i;
	end
endmodule

// ### testbench/test_spictl_top.sv
// Self-checking bench for spictl_top over AHB-Lite.
// Assumes a looped-back far end and a 40 MHz clock.
`timescale 1ns/100ps
module test_spictl_top;
	import spictl_pkg::*;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, r;
	logic [1:0]  htrans = 2'h0;
	wire  [31:0] hrdata;
	wire         hreadyout, hready, hresp, sck_o, sck_oe, mosi_o, mosi_oe, irq, miso_i, mosi_i, sck_i, sel_n_i, miso_oe;
	int          mismatches = 0, checked = 0, edges = 0, gap = 0, cur_baud = 0;
	logic        sck_p = 1'b0, cph = 1'b0, ord = 1'b0, gap_bad = 1'b0;
	logic [7:0]  sent;
	logic [31:0] frames [6] = '{32'h100000A5, 32'h3402003C, 32'h38010081, 32'h1CFF0315, 32'h10000101, 32'h300300C3};
	// The first value sets select enable in slave role, which ends the frame the
	// slave arms straight after reset before any master role is chosen.
	logic [7:0]  vals [3] = '{8'hC0, 8'hFF, 8'h5A};

	assign hready = hreadyout;
	spictl_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata,
		.hreadyout, .hresp, .sck_i, .sck_o, .sck_oe, .mosi_i, .mosi_o, .mosi_oe, .miso_i, .miso_o(), .miso_oe,
		.sel_n_i, .irq);
	spictl_far_end u_far (.hclk, .mosi_o, .mosi_oe, .miso_i, .mosi_i, .sck_i, .sel_n_i);

	// ---------------------------------------------------------------
	// Clock, watchdog and pin monitor
	// ---------------------------------------------------------------
	initial forever #12.5 hclk = ~hclk;
	initial begin
		#500000;
		mismatches++;
		end_of_test();
	end
	// Counts clock edges, their spacing, and the data bit seen at each latching edge.
	always @(posedge hclk) begin
		gap <= gap + 1;
		sck_p <= sck_o;
		if (sck_o !== sck_p && sck_oe === 1'b1) begin
			edges <= edges + 1;
			gap <= 1;
			if (edges > 0 && gap != cur_baud + 1)
				gap_bad <= 1'b1;
			if (edges % 2 == int'(cph) && edges < 16)
				sent[ord ? 7 - edges / 2 : edges / 2] <= mosi_o;
		end
	end

	task automatic check(input logic [31:0] got, exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One single transfer: address phase, then data phase, each held until hready.
	task automatic bus(input logic [31:0] a, wd, input logic w, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic run_frame(input logic [7:0] ctl, bd, md, dat, input logic skip, ovr);
		int         n;
		logic [7:0] mk;
		n = (md[2:0] == 3'h0) ? 8 : int'(md[2:0]);
		mk = 8'hFF >> (8 - n);
		bus(ADDR_BAUD, 32'(bd), 1'b1, r);
		bus(ADDR_MODE, 32'(md), 1'b1, r);
		bus(ADDR_CTRL, 32'(ctl), 1'b1, r);
		// A polarity change moves the idle clock two edges after the write; let the
		// monitor see it before its counts are cleared.
		repeat (3) @(posedge hclk);
		cur_baud = bd;
		cph = ctl[2];
		ord = ctl[5];
		edges = 0;
		gap_bad = 1'b0;
		sent = ~dat;
		bus(ADDR_DATA, 32'(dat), 1'b1, r);
		for (int i = 0; i < 5000 && edges < 2 * n; i++) @(posedge hclk);
		repeat (2 * bd + 8) @(posedge hclk);
		check(32'(edges), 32'(2 * n));
		check(32'(gap_bad), 32'h0);
		check(32'(sck_o), 32'(ctl[3]));
		check(32'(sent & mk), 32'(dat & mk));
		check(32'(irq), 32'(ovr));
		bus(ADDR_FLAGS, 32'h0, 1'b0, r);
		check(r & 32'h82, {24'h0, ovr, 5'h0, 2'h2});
		@(posedge hclk);
		check(32'(irq), 32'h0);
		if (!skip) begin
			bus(ADDR_DATA, 32'h0, 1'b0, r);
			check(r & 32'(mk), 32'(dat & mk));
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(ADDR_CTRL, 32'h0, 1'b0, r);
		check(r, 32'(CTRL_RESET));
		bus(ADDR_BAUD, 32'h0, 1'b0, r);
		check(r, 32'h0);
		check(32'(miso_oe), 32'h1);
		check(32'(hresp), 32'(HRESP_OKAY));
		for (int i = 0; i < 3; i++) begin
			bus(ADDR_CTRL, 32'(vals[i]), 1'b1, r);
			bus(ADDR_CTRL, 32'h0, 1'b0, r);
			check(r, 32'(vals[i] & CTRL_WMASK));
			bus(ADDR_MODE, 32'(vals[i]), 1'b1, r);
			bus(ADDR_MODE, 32'h0, 1'b0, r);
			check(r, 32'(vals[i] & MODE_WMASK));
		end
		// The slave frame cut by the select enable leaves its corrupt flag behind.
		bus(ADDR_FLAGS, 32'h0, 1'b0, r);
		check(r & 32'h10, 32'h10);
		bus(ADDR_BAUD, 32'hFF, 1'b1, r);
		bus(ADDR_BAUD, 32'h0, 1'b0, r);
		check(r, 32'h0);
		bus(ADDR_IMASK + 32'h4, 32'hFF, 1'b1, r);
		bus(ADDR_IMASK + 32'h4, 32'h0, 1'b0, r);
		check(r, 32'h0);
		bus(ADDR_IMASK, 32'h80, 1'b1, r);
		for (int i = 0; i < 6; i++)
			run_frame(frames[i][31:24], frames[i][23:16], frames[i][15:8], frames[i][7:0], i == 4, i == 5);
		end_of_test();
	end
endmodule
